// [core/bpc_defs.vh]
// Purpose: Shared constants of the pattern control and error insertion block.
// Assumes: Included by bpc_top.v only.
// Notes:   Counter and capture bytes 3..0 sit at rising addresses; seed bytes 0..3 do.
`ifndef BPC_DEFS_VH
`define BPC_DEFS_VH

// ****************************************************************
// Register map
// ****************************************************************
`define BPC_ADDR_SEED_BASE 8'h00
`define BPC_ADDR_PLEN 8'h04
`define BPC_ADDR_PTAP 8'h05
`define BPC_ADDR_PCTL 8'h06
`define BPC_ADDR_EICTL 8'h07
`define BPC_ADDR_BCNT_BASE 8'h08
`define BPC_ADDR_ECNT_BASE 8'h0C
`define BPC_ADDR_CAP_BASE 8'h10
`define BPC_REG_RESET 8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define BPC_PC_LOAD 7
`define BPC_PC_ZSUP 6
`define BPC_PC_KIND 5
`define BPC_PC_LATCH 4
`define BPC_PC_CAPT 3
`define BPC_PC_ARDIS 2
`define BPC_PC_RESYNC 1
`define BPC_PC_LOOP 0
`define BPC_EI_TXINV 5
`define BPC_EI_RXINV 4
`define BPC_EI_SBE 3
`define BPC_EI_RATE_MSB 2
`define BPC_EI_RATE_LSB 0
`define BPC_EI_USED 8'h3F
`define BPC_LEN_USED 8'h1F

// ****************************************************************
// Error rate terminal counts (bits per inserted error, minus one)
// ****************************************************************
`define BPC_RATE1_LAST 24'd9
`define BPC_RATE2_LAST 24'd99
`define BPC_RATE3_LAST 24'd999
`define BPC_RATE4_LAST 24'd9999
`define BPC_RATE5_LAST 24'd99999
`define BPC_RATE6_LAST 24'd999999
`define BPC_RATE7_LAST 24'd9999999

// ****************************************************************
// Generator and synchroniser figures
// ****************************************************************
`define BPC_ZERO_RUN 4'd14
`define BPC_ZERO_SAT 4'hF
`define BPC_SYNC_GOOD_LAST 6'd31
`define BPC_ERR_STEP 6'd8
`define BPC_LOSS_LEVEL 6'd32
`define BPC_PIN_RESET 10'h1C0

`endif

// [core/bpc_fifo.v]
// Purpose: Small synchronous FIFO between pattern generator and transmit pin.
// Assumes: One clock; flush empties it in one cycle.
// Notes:   Width and depth are parameters; depth must be a power of two.
`default_nettype none

module bpc_fifo #(
  parameter W = 1,
  parameter D = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire rst_n,
  input wire flush,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wptr;
  reg [AW-1:0] rptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  assign in_ready = (count != D[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem[wptr] <= in_data;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr <= {AW{1'b0}};
      rptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else if (flush) begin
      wptr <= {AW{1'b0}};
      rptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wptr <= wptr + 1'b1;
      end
      if (pop) begin
        rptr <= rptr + 1'b1;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // bpc_fifo

`default_nettype wire

// [core/bpc_top.v]
// Purpose: Pattern control, loopback, inversion and error insertion of a BER tester.
// Assumes: CLK well above TCLK and RCLK; all pins are synchronised here.
// Notes:   Multiplexed 8-bit bus with ALE, RD_N, WR_N and CS_N, all active as usual.
`default_nettype none
`include "bpc_defs.vh"

module bpc_top #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  input wire CLK,
  input wire RST_N,
  input wire [7:0] AD_IN,
  output reg [7:0] AD_OUT,
  output wire AD_OE,
  input wire ALE,
  input wire RD_N,
  input wire WR_N,
  input wire CS_N,
  input wire LOAD_PIN,
  input wire LATCH_PIN,
  input wire CAPTURE_PIN,
  input wire TCLK,
  input wire RCLK,
  input wire RDATA,
  output reg TDATA
);
  localparam I_ALE = 9;
  localparam I_RD = 8;
  localparam I_WR = 7;
  localparam I_CS = 6;
  localparam I_LOAD = 5;
  localparam I_LATCH = 4;
  localparam I_CAPT = 3;
  localparam I_TCLK = 2;
  localparam I_RCLK = 1;
  localparam I_RDATA = 0;
  localparam ST_HUNT = 2'b00;
  localparam ST_SYNC = 2'b01;
  localparam ST_LOST = 2'b10;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  wire [9:0] pin_raw = {ALE, RD_N, WR_N, CS_N, LOAD_PIN, LATCH_PIN, CAPTURE_PIN,
                        TCLK, RCLK, RDATA};
  reg [9:0] pin_s1;
  reg [9:0] pin_s2;
  reg [9:0] pin_s3;
  reg [7:0] ad_s1;
  reg [7:0] ad_s2;

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_s1 <= `BPC_PIN_RESET;
      pin_s2 <= `BPC_PIN_RESET;
      pin_s3 <= `BPC_PIN_RESET;
      ad_s1 <= 8'h00;
      ad_s2 <= 8'h00;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      ad_s1 <= AD_IN;
      ad_s2 <= ad_s1;
    end
  end

  wire tclk_rise = pin_s2[I_TCLK] & ~pin_s3[I_TCLK];
  wire rclk_rise = pin_s2[I_RCLK] & ~pin_s3[I_RCLK];

  // ****************************************************************
  // Register port
  // ****************************************************************
  reg [7:0] addr;
  reg [7:0] seed [0:3];
  reg [7:0] plen;
  reg [7:0] ptap;
  reg [7:0] pctl;
  reg [7:0] eictl;
  reg [31:0] bcnt_reg;
  reg [31:0] ecnt_reg;
  reg [31:0] cap_reg;
  reg [7:0] rd_mux;
  integer k;

  // Both edges and data pass the same two stages, so data and strobe stay aligned
  wire ale_fall = pin_s3[I_ALE] & ~pin_s2[I_ALE];
  wire wr_rise = ~pin_s3[I_WR] & pin_s2[I_WR] & ~pin_s3[I_CS];
  assign AD_OE = ~pin_s2[I_RD] & ~pin_s2[I_CS];

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      addr <= 8'h00;
      plen <= `BPC_REG_RESET;
      ptap <= `BPC_REG_RESET;
      pctl <= `BPC_REG_RESET;
      eictl <= `BPC_REG_RESET;
      for (k = 0; k < 4; k = k + 1) begin
        seed[k] <= `BPC_REG_RESET;
      end
    end else begin
      if (ale_fall) begin
        addr <= ad_s2;
      end
      if (wr_rise) begin
        case (addr)
          `BPC_ADDR_SEED_BASE, `BPC_ADDR_SEED_BASE + 8'h01,
          `BPC_ADDR_SEED_BASE + 8'h02, `BPC_ADDR_SEED_BASE + 8'h03: begin
            seed[addr[1:0]] <= ad_s2;
          end
          `BPC_ADDR_PLEN: plen <= ad_s2 & `BPC_LEN_USED;
          `BPC_ADDR_PTAP: ptap <= ad_s2 & `BPC_LEN_USED;
          `BPC_ADDR_PCTL: pctl <= ad_s2;
          `BPC_ADDR_EICTL: eictl <= ad_s2 & `BPC_EI_USED;
          default: ;
        endcase
      end
    end
  end

  // Lowest address of a counter or capture group holds its top byte
  function [7:0] pick;
    input [31:0] w;
    input [1:0] a;
    begin
      case (a)
        2'd0: pick = w[31:24];
        2'd1: pick = w[23:16];
        2'd2: pick = w[15:8];
        default: pick = w[7:0];
      endcase
    end
  endfunction

  always @* begin
    case ({2'b00, addr[7:2]})
      `BPC_ADDR_SEED_BASE >> 2: rd_mux = seed[addr[1:0]];
      `BPC_ADDR_PLEN >> 2: begin
        case (addr[1:0])
          2'd0: rd_mux = plen;
          2'd1: rd_mux = ptap;
          2'd2: rd_mux = pctl;
          default: rd_mux = eictl;
        endcase
      end
      `BPC_ADDR_BCNT_BASE >> 2: rd_mux = pick(bcnt_reg, addr[1:0]);
      `BPC_ADDR_ECNT_BASE >> 2: rd_mux = pick(ecnt_reg, addr[1:0]);
      `BPC_ADDR_CAP_BASE >> 2: rd_mux = pick(cap_reg, addr[1:0]);
      default: rd_mux = 8'h00;
    endcase
  end

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      AD_OUT <= 8'h00;
    end else begin
      AD_OUT <= rd_mux;
    end
  end

  // ****************************************************************
  // Strobes: register bit OR pin (resync and single error: bit only), rising edge in the CLK domain
  // ****************************************************************
  wire [4:0] stb_lvl = {pctl[`BPC_PC_LOAD] | pin_s2[I_LOAD],
                        pctl[`BPC_PC_LATCH] | pin_s2[I_LATCH],
                        pctl[`BPC_PC_CAPT] | pin_s2[I_CAPT],
                        pctl[`BPC_PC_RESYNC], eictl[`BPC_EI_SBE]};
  reg [4:0] stb_prev;
  wire [4:0] stb_rise = stb_lvl & ~stb_prev;
  wire load_rise = stb_rise[4];
  wire latch_rise = stb_rise[3];
  wire capt_rise = stb_rise[2];
  wire resync_rise = stb_rise[1];
  wire sbe_rise = stb_rise[0];

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      stb_prev <= 5'h00;
    end else begin
      stb_prev <= stb_lvl;
    end
  end

  // ****************************************************************
  // Pattern generator feeding the transmit FIFO
  // ****************************************************************
  wire zsup = pctl[`BPC_PC_ZSUP];
  wire kind_prbs = pctl[`BPC_PC_KIND];
  reg [31:0] gen;
  reg [3:0] zrun;
  wire gen_fb = kind_prbs ? (gen[plen[4:0]] ^ gen[ptap[4:0]]) : gen[plen[4:0]];
  wire gen_bit = gen_fb | (zsup & (zrun == `BPC_ZERO_RUN));
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire fifo_out_data;
  // A new load flushes stale bits so the fresh pattern leaves within one bit
  wire gen_step = fifo_in_ready & ~load_rise;

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      gen <= 32'h00000000;
      zrun <= 4'h0;
    end else if (load_rise) begin
      gen <= {seed[3], seed[2], seed[1], seed[0]};
      zrun <= 4'h0;
    end else if (gen_step) begin
      gen <= {gen[30:0], gen_fb};
      if (gen_bit) begin
        zrun <= 4'h0;
      end else if (zrun != `BPC_ZERO_SAT) begin
        zrun <= zrun + 4'h1;
      end
    end
  end

  bpc_fifo #(
    .W(1),
    .D(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk(CLK),
    .rst_n(RST_N),
    .flush(load_rise),
    .in_valid(~load_rise),
    .in_ready(fifo_in_ready),
    .in_data(gen_bit),
    .out_valid(fifo_out_valid),
    .out_ready(tclk_rise),
    .out_data(fifo_out_data)
  );

  // ****************************************************************
  // Error insertion and transmit pin
  // ****************************************************************
  wire [2:0] rate_code = eictl[`BPC_EI_RATE_MSB:`BPC_EI_RATE_LSB];
  reg [23:0] rate_last;
  reg [23:0] rate_cnt;
  reg sbe_pend;
  wire tx_take = tclk_rise & fifo_out_valid;

  always @* begin
    case (rate_code)
      3'd1: rate_last = `BPC_RATE1_LAST;
      3'd2: rate_last = `BPC_RATE2_LAST;
      3'd3: rate_last = `BPC_RATE3_LAST;
      3'd4: rate_last = `BPC_RATE4_LAST;
      3'd5: rate_last = `BPC_RATE5_LAST;
      3'd6: rate_last = `BPC_RATE6_LAST;
      default: rate_last = `BPC_RATE7_LAST;
    endcase
  end

  wire rate_hit = (rate_code != 3'd0) & (rate_cnt == rate_last);
  wire err_now = sbe_pend | rate_hit;
  wire tx_bit = fifo_out_data ^ eictl[`BPC_EI_TXINV] ^ err_now;

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rate_cnt <= 24'h000000;
      sbe_pend <= 1'b0;
      TDATA <= 1'b0;
    end else begin
      if (rate_code == 3'd0) begin
        rate_cnt <= 24'h000000;
      end else if (tx_take) begin
        rate_cnt <= rate_hit ? 24'h000000 : rate_cnt + 24'h000001;
      end
      // A new strobe wins over consumption of the previous one
      if (sbe_rise) begin
        sbe_pend <= 1'b1;
      end else if (tx_take) begin
        sbe_pend <= 1'b0;
      end
      if (tx_take) begin
        TDATA <= tx_bit;
      end
    end
  end

  // ****************************************************************
  // Receive path, synchroniser and counters
  // ****************************************************************
  wire loop = pctl[`BPC_PC_LOOP];
  wire rx_take = loop ? tx_take : rclk_rise;
  wire rx_raw = loop ? tx_bit : pin_s2[I_RDATA];
  wire rx_bit = rx_raw ^ eictl[`BPC_EI_RXINV];
  reg [31:0] rsh;
  reg [1:0] state;
  reg [5:0] good;
  reg [5:0] score;
  reg [31:0] bcnt_int;
  reg [31:0] ecnt_int;
  wire rx_expect = kind_prbs ? (rsh[plen[4:0]] ^ rsh[ptap[4:0]]) : rsh[plen[4:0]];
  wire rx_err = rx_bit ^ rx_expect;
  wire cnt_on = rx_take & (state == ST_SYNC);
  wire lose = rx_err & ((score + `BPC_ERR_STEP) >= `BPC_LOSS_LEVEL);

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rsh <= 32'h00000000;
      state <= ST_HUNT;
      good <= 6'd0;
      score <= 6'd0;
    end else begin
      if (rx_take) begin
        rsh <= {rsh[30:0], rx_bit};
      end
      if (resync_rise) begin
        state <= ST_HUNT;
        good <= 6'd0;
        score <= 6'd0;
      end else if (rx_take) begin
        case (state)
          ST_HUNT: begin
            if (rx_err) begin
              good <= 6'd0;
            end else if (good == `BPC_SYNC_GOOD_LAST) begin
              state <= ST_SYNC;
              score <= 6'd0;
            end else begin
              good <= good + 6'd1;
            end
          end
          ST_SYNC: begin
            if (lose) begin
              state <= pctl[`BPC_PC_ARDIS] ? ST_LOST : ST_HUNT;
              good <= 6'd0;
            end else if (rx_err) begin
              score <= score + `BPC_ERR_STEP;
            end else if (score != 6'd0) begin
              score <= score - 6'd1;
            end
          end
          ST_LOST: state <= ST_LOST;
          default: state <= ST_HUNT;
        endcase
      end
    end
  end

  // Latch edge and a same-cycle bit both survive: the bit starts the new count
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      bcnt_int <= 32'h00000000;
      ecnt_int <= 32'h00000000;
      bcnt_reg <= 32'h00000000;
      ecnt_reg <= 32'h00000000;
      cap_reg <= 32'h00000000;
    end else begin
      if (latch_rise) begin
        bcnt_reg <= bcnt_int;
        ecnt_reg <= ecnt_int;
        bcnt_int <= {31'h00000000, cnt_on};
        ecnt_int <= {31'h00000000, cnt_on & rx_err};
      end else begin
        if (cnt_on) begin
          bcnt_int <= bcnt_int + 32'h00000001;
        end
        if (cnt_on & rx_err) begin
          ecnt_int <= ecnt_int + 32'h00000001;
        end
      end
      if (capt_rise) begin
        cap_reg <= rsh;
      end
    end
  end
endmodule // bpc_top

`default_nettype wire

// [verification/bpc_top_monitor.sv]
// Purpose: Port checks of the BER tester control block.
// Assumes: Bound into bpc_top; link clocks stay at or below CLK/6.
// Notes:   Transmit checks lean on the age of the last TCLK rise.
`default_nettype none
module bpc_top_monitor (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic RD_N,
  input wire logic CS_N,
  input wire logic AD_OE,
  input wire logic TCLK,
  input wire logic TDATA
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Transmit clock age and checks
  // ****
  // Saturates, so a stopped link clock reads as F
  logic [3:0] since_tr;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N)
      since_tr <= 4'hF;
    else if ($rose(TCLK))
      since_tr <= 4'h0;
    else if (since_tr != 4'hF)
      since_tr <= since_tr + 4'h1;
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  tx_edge_delay_a: assert property (
    $changed(TDATA) |-> since_tr >= 4'h1 && since_tr <= 4'h4)
    else $error("TDATA moved away from a TCLK rise");
  tx_bit_hold_a: assert property ($changed(TDATA) |=> $stable(TDATA) [*5])
    else $error("TDATA changed twice within one bit");
  tx_idle_a: assert property (since_tr == 4'hF |-> $stable(TDATA))
    else $error("TDATA changed with TCLK stopped");
  rst_quiet_a: assert property ($rose(RST_N) |-> !AD_OE && !TDATA)
    else $error("outputs not quiet after reset");
  oe_rise_a: assert property ($fell(RD_N) && !CS_N |-> ##[1:4] AD_OE)
    else $error("bus not driven during a read");
  oe_fall_a: assert property ($rose(RD_N) |-> ##[1:4] !AD_OE)
    else $error("bus still driven after a read");
  oe_cause_a: assert property (AD_OE |-> !$past(RD_N, 2) || !$past(RD_N, 3))
    else $error("bus driven without a read");
  oe_hold_a: assert property (AD_OE && !RD_N && !CS_N |=> AD_OE)
    else $error("bus dropped inside a read");
  oe_idle_a: assert property (RD_N [*4] |-> !AD_OE)
    else $error("bus driven while idle");
endmodule // bpc_top_monitor
`default_nettype wire

// [verification/bpc_top_partner.sv]
// Purpose: Far end of the serial link: both clocks and an echo of TDATA.
// Assumes: TDATA settles well inside one bit.
// Notes:   garble makes RDATA toggle instead of echoing.
`default_nettype none
module bpc_top_partner (
  input wire logic run,
  input wire logic garble,
  input wire logic tdata,
  output logic tclk,
  output logic rclk,
  output logic rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic held;
  initial begin
    tclk = 1'b0;
    rclk = 1'b0;
    rdata = 1'b0;
    held = 1'b0;
    #7;
    forever begin
      tclk = run;
      rclk = run;
      #160;
      tclk = 1'b0;
      rclk = 1'b0;
      // Off-frame or garbled, the line never repeats the last echo
      rdata = (run && !garble) ? held : ~rdata;
      #140;
      // Taken late in the bit, after the NRZ change has settled
      held = tdata;
      #20;
    end
  end
endmodule // bpc_top_partner
`default_nettype wire

// [verification/bpc_top_tb.sv]
// Purpose: Self-checking bench of the BER tester control block.
// Assumes: Partner echoes TDATA on RDATA; bits last 8 CLK.
// Notes:   Error rates are counted on TDATA with an all-ones pattern.
`default_nettype none
module bpc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 1'b0, RST_N = 1'b0, ALE = 1'b0, RD_N = 1'b1, WR_N = 1'b1, CS_N = 1'b1;
  logic LOAD_PIN = 1'b0, LATCH_PIN = 1'b0, CAPTURE_PIN = 1'b0, run = 1'b0, garble = 1'b0;
  logic [7:0] AD_IN = 8'h00;
  logic [7:0] AD_OUT;
  logic AD_OE, TCLK, RCLK, RDATA, TDATA;
  int mismatches = 0, checks = 0;
  bpc_top i_dut (.CLK(CLK), .RST_N(RST_N), .AD_IN(AD_IN), .AD_OUT(AD_OUT), .AD_OE(AD_OE),
    .ALE(ALE), .RD_N(RD_N), .WR_N(WR_N), .CS_N(CS_N), .LOAD_PIN(LOAD_PIN),
    .LATCH_PIN(LATCH_PIN), .CAPTURE_PIN(CAPTURE_PIN), .TCLK(TCLK), .RCLK(RCLK),
    .RDATA(RDATA), .TDATA(TDATA));
  bpc_top_partner i_far (.run(run), .garble(garble), .tdata(TDATA), .tclk(TCLK),
    .rclk(RCLK), .rdata(RDATA));
  always #20 CLK = ~CLK;
  // ****
  // Shared tasks
  // ****
  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic stuck;
    mismatches++;
    give_verdict();
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      mismatches++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  function automatic logic [31:0] rng(input logic [31:0] v, input logic [31:0] lo,
    input logic [31:0] hi);
    return {31'h0, v >= lo && v <= hi};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge CLK);
  endtask
  task automatic addr(input logic [7:0] a);
    AD_IN = a;
    ALE = 1'b1;
    CS_N = 1'b0;
    cyc(4);
    ALE = 1'b0;
    cyc(4);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr(a);
    AD_IN = d;
    WR_N = 1'b0;
    cyc(4);
    WR_N = 1'b1;
    cyc(4);
    CS_N = 1'b1;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int k;
    addr(a);
    RD_N = 1'b0;
    k = 0;
    while (AD_OE !== 1'b1) begin
      cyc(1);
      k++;
      if (k > 8)
        stuck();
    end
    cyc(2);
    d = {24'h0, AD_OUT};
    RD_N = 1'b1;
    cyc(4);
    CS_N = 1'b1;
    cyc(1);
  endtask
  // Lowest address holds the top byte
  task automatic rd32(input logic [7:0] b, output logic [31:0] v);
    logic [31:0] x;
    for (int i = 0; i < 4; i++) begin
      rd(b + i[7:0], x);
      v = {v[23:0], x[7:0]};
    end
  endtask
  task automatic pulse(input int w);
    LOAD_PIN = (w == 0);
    LATCH_PIN = (w == 1);
    CAPTURE_PIN = (w == 2);
    cyc(4);
    {LOAD_PIN, LATCH_PIN, CAPTURE_PIN} = 3'h0;
    cyc(4);
  endtask
  // Two latch edges 8n CLK apart frame n received bits
  task automatic period(input int n, output logic [31:0] b, output logic [31:0] e);
    pulse(1);
    cyc(8 * n - 8);
    pulse(1);
    rd32(8'h08, b);
    rd32(8'h0C, e);
  endtask
  task automatic cfg(input logic [7:0] len, input logic [7:0] ctl, input logic pin);
    // All-ones seeds suit both kinds; zero suppression is never set
    for (int i = 0; i < 4; i++)
      wr(i[7:0], 8'hFF);
    wr(8'h04, len);
    wr(8'h05, 8'h00);
    wr(8'h06, ctl);
    if (pin)
      pulse(0);
    else
      wr(8'h06, ctl | 8'h80);
    wr(8'h06, ctl);
    cyc(400);
  endtask
  // Counts zeros on TDATA, sampled mid-bit from the next TCLK rise
  task automatic zeros(input int n, output logic [31:0] z);
    logic p;
    int k;
    p = 1'b1;
    k = 0;
    while (p !== 1'b0 || TCLK !== 1'b1) begin
      p = TCLK;
      cyc(1);
      k++;
      if (k > 20)
        stuck();
    end
    cyc(6);
    z = 32'h0;
    for (int i = 0; i < n; i++) begin
      z = z + {31'h0, ~TDATA};
      cyc(8);
    end
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_regs;
    logic [31:0] d;
    rd(8'h07, d);
    chk(d, 32'h0);
    wr(8'h07, 8'h3F);
    rd(8'h07, d);
    chk(d, 32'h3F);
    for (int c = 0; c < 8; c++) begin
      wr(8'h07, c[7:0]);
      rd(8'h07, d);
      chk(d, c);
    end
    rd(8'h20, d);
    chk(d, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_tx;
    logic [31:0] z;
    int n[3] = '{40, 100, 200};
    int w[3] = '{0, 10, 2};
    cfg(8'h00, 8'h01, 1'b0);
    for (int c = 0; c < 3; c++) begin
      wr(8'h07, c[7:0]);
      zeros(n[c], z);
      chk(z, w[c]);
    end
    // Stop automatic errors first, so only the single error lands in the window
    wr(8'h07, 8'h00);
    fork
      zeros(40, z);
      begin
        cyc(40);
        wr(8'h07, 8'h08);
      end
    join
    chk(z, 32'h1);
    wr(8'h07, 8'h20);
    zeros(16, z);
    chk(z, 32'h10);
    wr(8'h07, 8'h00);
    $display("test tx done");
  endtask
  task automatic t_rx;
    logic [31:0] b, e, c;
    cfg(8'h00, 8'h01, 1'b1);
    garble = 1'b1;
    period(40, b, e);
    chk(rng(b, 39, 41), 32'h1);
    chk(e, 32'h0);
    pulse(2);
    rd32(8'h10, c);
    chk(c, 32'hFFFFFFFF);
    LATCH_PIN = 1'b1;
    cyc(4);
    rd32(8'h08, b);
    cyc(160);
    rd32(8'h08, e);
    chk(e, b);
    LATCH_PIN = 1'b0;
    wr(8'h06, 8'h00);
    cyc(160);
    period(40, b, e);
    chk(b, 32'h0);
    pulse(2);
    rd32(8'h10, c);
    chk({31'h0, c === 32'hAAAAAAAA || c === 32'h55555555}, 32'h1);
    garble = 1'b0;
    cyc(400);
    period(40, b, e);
    chk(rng(b, 39, 41), 32'h1);
    $display("test rx done");
  endtask
  task automatic t_inv;
    logic [31:0] b, e;
    cfg(8'h06, 8'h21, 1'b1);
    wr(8'h07, 8'h30);
    cyc(400);
    period(40, b, e);
    chk(rng(b, 39, 41), 32'h1);
    chk(e, 32'h0);
    wr(8'h06, 8'h25);
    wr(8'h07, 8'h20);
    cyc(160);
    wr(8'h07, 8'h30);
    cyc(400);
    period(40, b, e);
    chk(b, 32'h0);
    wr(8'h06, 8'h27);
    wr(8'h06, 8'h25);
    cyc(400);
    period(40, b, e);
    chk(rng(b, 39, 41), 32'h1);
    $display("test inv done");
  endtask
  initial begin
    repeat (6) @(negedge CLK);
    RST_N = 1'b1;
    cyc(4);
    run = 1'b1;
    t_regs();
    t_tx();
    t_rx();
    t_inv();
    give_verdict();
  end
endmodule // bpc_top_tb
bind bpc_top bpc_top_monitor i_mon (.CLK(CLK), .RST_N(RST_N), .RD_N(RD_N), .CS_N(CS_N),
  .AD_OE(AD_OE), .TCLK(TCLK), .TDATA(TDATA));
`default_nettype wire
